// File: cpsr_regs.sv
`timescale 1ns/1ps
`include "cpsr_defs.svh"

module cpsr_regs
   import cpsr_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire cpsr_exec_s        exec,
   input  wire logic              acc_load,
   input  wire logic [7:0]        acc_value,
   input  wire logic              push_req,
   input  wire logic [7:0]        push_data,
   input  wire logic              pop_req,
   input  wire logic              data_pointer_word_load,
   input  wire logic [15:0]       data_pointer_word_value,
   output logic [15:0]            data_pointer_word,
   output logic [7:0]             stack_top_pointer,
   output logic [7:0]             program_status_word,
   output logic [7:0]             primary_operand_register,
   output logic [4:0]             bank_base,
   output logic                   stk_we,
   output logic [7:0]             stk_addr,
   output logic [7:0]             stk_data
);

   // ==========================================================
   // State and decode
   // stack pointer comes out of reset at seven
   localparam cpsr_state_s ST_RST = '{
      sp      : `CPSR_RST_SP,
      default : '0
   };

   cpsr_state_s q;
   cpsr_state_s d;
   cpsr_flags_s fl;
   logic [7:0]  idx;
   logic        hit;
   logic        access;
   logic        wr_commit;
   logic        sw_sp;
   logic        sw_dpl;
   logic        sw_dph;
   logic        sw_psw;
   logic        sw_acc;
   logic        arith;
   logic [7:0]  acc_nx;
   logic        par_nx;
   logic [31:0] rd_word;

   // Index from a word address; stray high or low bits miss
   assign idx    = paddr[9:2];
   assign access = psel && penable;

   // only five indices answer, all else is reserved
   always_comb begin
      unique case (idx)
         `CPSR_IDX_SP, `CPSR_IDX_DPL, `CPSR_IDX_DPH,
         `CPSR_IDX_PSW, `CPSR_IDX_ACC: begin
            hit = (paddr[1:0] == 2'b00) &&
                  (paddr[ADDR_W-1:10] == '0);
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   // Writes land on the edge that completes the access phase
   assign wr_commit = access && q.pready && pwrite && hit && pstrb[0];
   assign sw_sp     = wr_commit && (idx == `CPSR_IDX_SP);
   assign sw_dpl    = wr_commit && (idx == `CPSR_IDX_DPL);
   assign sw_dph    = wr_commit && (idx == `CPSR_IDX_DPH);
   assign sw_psw    = wr_commit && (idx == `CPSR_IDX_PSW);
   assign sw_acc    = wr_commit && (idx == `CPSR_IDX_ACC);
   assign arith     = exec.op != CPSR_OP_NONE;

   // ==========================================================
   // Read mux; narrow registers sit in the low byte
   always_comb begin
      rd_word = 32'h0000_0000;
      if (hit) begin
         unique case (idx)
            `CPSR_IDX_SP:  rd_word[7:0] = q.sp;
            `CPSR_IDX_DPL: rd_word[7:0] = q.data_pointer_low;
            `CPSR_IDX_DPH: rd_word[7:0] = q.data_pointer_high;
            `CPSR_IDX_PSW: rd_word[7:0] = program_status_word;
            `CPSR_IDX_ACC: rd_word[7:0] = q.acc;
            default:       rd_word[7:0] = 8'h00;
         endcase
      end
   end

   // ==========================================================
   // Arithmetic and parity helpers
   cpsr_alu_flags u_alu (
      .op    (exec.op),
      .a     (q.acc),
      .b     (exec.operand_b),
      .cy_in (q.cy),
      .flags (fl)
   );

   // Accumulator priority: software, then direct load, then arithmetic
   always_comb begin
      acc_nx = q.acc;
      if (arith) begin
         acc_nx = fl.result;
      end
      if (acc_load) begin
         acc_nx = acc_value;
      end
      if (sw_acc) begin
         acc_nx = pwdata[7:0];
      end
   end

   // Parity is taken from the next accumulator so it never lags
   cpsr_parity #(
      .WIDTH (8)
   ) u_par (
      .data (acc_nx),
      .odd  (par_nx)
   );

   // ==========================================================
   // Next state
   always_comb begin
      d        = q;
      d.pready = 1'b0;
      d.stk_we = 1'b0;
      // One wait state; data and error are latched with ready
      if (access && !q.pready) begin
         d.pready  = 1'b1;
         d.prdata  = rd_word;
         d.pslverr = !hit;
      end
      d.acc = acc_nx;
      d.parity = par_nx;
      // each of the five ops rewrites overflow
      if (arith) begin
         d.ov = fl.ov;
         d.cy = fl.cy;
         // nibble carry, cleared by multiply and divide
         d.ac = fl.ac;
      end
      // increment first, then write at new top
      if (push_req) begin
         d.sp       = q.sp + 8'h01;
         d.stk_we   = 1'b1;
         d.stk_addr = q.sp + 8'h01;
         d.stk_data = push_data;
      end else if (pop_req) begin
         d.sp = q.sp - 8'h01;
      end
      if (data_pointer_word_load) begin
         d.data_pointer_high = data_pointer_word_value[15:8];
         d.data_pointer_low = data_pointer_word_value[7:0];
      end
      // Software wins over the datapath in the same cycle
      if (sw_sp) begin
         d.sp = pwdata[7:0];
      end
      if (sw_dpl) begin
         d.data_pointer_low = pwdata[7:0];
      end
      if (sw_dph) begin
         d.data_pointer_high = pwdata[7:0];
      end
      if (sw_psw) begin
         d.cy   = pwdata[`CPSR_PSW_CY];
         d.ac   = pwdata[`CPSR_PSW_AC];
         d.f0   = pwdata[`CPSR_PSW_F0];
         d.bank = pwdata[`CPSR_PSW_BANK_HI:`CPSR_PSW_BANK_LO];
         d.ov   = pwdata[`CPSR_PSW_OV];
         d.f1   = pwdata[`CPSR_PSW_F1];
      end
      // bank base is eight bytes per bank
      d.bank_base = {d.bank, 3'b000};
   end

   // ==========================================================
   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= ST_RST;
      end else begin
         q <= d;
      end
   end

   // ==========================================================
   // Outputs, all from flops
   assign prdata                   = q.prdata;
   assign pready                   = q.pready;
   assign pslverr                  = q.pslverr;
   assign data_pointer_word        = {q.data_pointer_high, q.data_pointer_low};
   assign stack_top_pointer        = q.sp;
   assign primary_operand_register = q.acc;
   assign bank_base                = q.bank_base;
   assign stk_we                   = q.stk_we;
   assign stk_addr                 = q.stk_addr;
   assign stk_data                 = q.stk_data;
   assign program_status_word = {q.cy, q.ac, q.f0, q.bank,
                                 q.ov, q.f1, q.parity};

   // ==========================================================
   // Checks
   logic [8:0]  chk_sum;
   logic [4:0]  chk_nib;
   logic [15:0] chk_prod;
   logic        chk_addov;
   logic        dp_quiet;

   assign chk_sum   = {1'b0, q.acc} + {1'b0, exec.operand_b};
   assign chk_nib   = {1'b0, q.acc[3:0]} + {1'b0, exec.operand_b[3:0]};
   assign chk_prod  = {8'h00, q.acc} * {8'h00, exec.operand_b};
   assign chk_addov = (q.acc[7] == exec.operand_b[7]) &&
                      (chk_sum[7] != q.acc[7]);
   assign dp_quiet  = !sw_psw && !sw_acc && !acc_load;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_access_start;
      psel && penable && !pready;
   endsequence

   sequence s_add_issue;
      exec.op == CPSR_OP_ADD && dp_quiet;
   endsequence

   a_apb_one_wait: assert property (
      s_access_start |=> pready ##1 !pready)
      else $error("ready not one cycle after access start");

   a_unmapped_err: assert property (
      s_access_start and !hit |=> pready && pslverr && prdata == 32'h0)
      else $error("unmapped access not flagged");

   a_sp_reset_val: assert property (
      $rose(presetn) |-> stack_top_pointer == `CPSR_RST_SP)
      else $error("stack pointer reset value wrong");

   a_acc_dph_reset: assert property (
      $rose(presetn) |-> primary_operand_register == 8'h00 &&
                         data_pointer_word == 16'h0000)
      else $error("accumulator or pointer not zero after reset");

   a_push_pre_inc: assert property (
      push_req && !sw_sp |=> stk_we && stk_addr == stack_top_pointer &&
                            stack_top_pointer == $past(q.sp) + 8'h01)
      else $error("push did not pre-increment");

   a_dph_write: assert property (
      sw_dph |=> data_pointer_word[15:8] == $past(pwdata[7:0]))
      else $error("high pointer byte write lost");

   a_dpl_write: assert property (
      sw_dpl |=> data_pointer_word[7:0] == $past(pwdata[7:0]))
      else $error("low pointer byte write lost");

   a_carry_add: assert property (
      s_add_issue |=> program_status_word[7] == $past(chk_sum[8]))
      else $error("carry after add wrong");

   a_nibble_add: assert property (
      s_add_issue |=> program_status_word[6] == $past(chk_nib[4]))
      else $error("nibble carry after add wrong");

   a_ov_add: assert property (
      s_add_issue |=> program_status_word[2] == $past(chk_addov))
      else $error("overflow after add wrong");

   a_ov_mul: assert property (
      exec.op == CPSR_OP_MUL && dp_quiet |=>
         program_status_word[2] == $past(chk_prod > 16'h00ff) &&
         !program_status_word[7] && !program_status_word[6])
      else $error("product overflow wrong");

   a_ov_div_zero: assert property (
      exec.op == CPSR_OP_DIV && exec.operand_b == 8'h00 && dp_quiet
         |=> program_status_word[2])
      else $error("divide by zero not flagged");

   a_ov_clear: assert property (
      exec.op == CPSR_OP_DIV && exec.operand_b != 8'h00 && dp_quiet
         |=> !program_status_word[2])
      else $error("overflow not cleared");

   a_user_flags: assert property (
      !sw_psw |=> $stable(program_status_word[5]) &&
                  $stable(program_status_word[1]))
      else $error("user flag changed by hardware");

   a_bank_map: assert property (
      bank_base == {program_status_word[4:3], 3'b000})
      else $error("bank base mismatch");

   a_parity_odd: assert property (
      program_status_word[0] == ^primary_operand_register)
      else $error("parity does not match accumulator");

   a_parity_ro: assert property (
      sw_psw && !sw_acc && !acc_load && !arith |=>
         program_status_word[0] == $past(program_status_word[0]))
      else $error("parity bit took a software write");

endmodule

// File: cpsr_defs.svh
`ifndef CPSR_DEFS_SVH
`define CPSR_DEFS_SVH

// ==========================================================
// Register indices; byte address is four times the index
`define CPSR_IDX_SP      8'h81
`define CPSR_IDX_DPL     8'h82
`define CPSR_IDX_DPH     8'h83
`define CPSR_IDX_PSW     8'hd0
`define CPSR_IDX_ACC     8'he0
// Reserved indices, answered as unmapped
`define CPSR_IDX_RSV_LO  8'h97
`define CPSR_IDX_RSV_HI  8'hf5

// ==========================================================
// Reset values
`define CPSR_RST_SP      8'h07
`define CPSR_RST_ZERO    8'h00

// ==========================================================
// Status word field positions
`define CPSR_PSW_CY      7
`define CPSR_PSW_AC      6
`define CPSR_PSW_F0      5
`define CPSR_PSW_BANK_HI 4
`define CPSR_PSW_BANK_LO 3
`define CPSR_PSW_OV      2
`define CPSR_PSW_F1      1
`define CPSR_PSW_PAR     0

// ==========================================================
// Arithmetic limits and bank layout
`define CPSR_MUL_MAX     16'h00ff
`define CPSR_BANK_SHIFT  3

`endif

// File: cpsr_pkg.sv
package cpsr_pkg;

   // ==========================================================
   // Datapath operation kinds
   typedef enum logic [2:0] {
      CPSR_OP_NONE,
      CPSR_OP_ADD,
      CPSR_OP_ADD_WITH_CARRY_OP,
      CPSR_OP_SUBTRACT_BORROW_OP,
      CPSR_OP_MUL,
      CPSR_OP_DIV
   } cpsr_op_e;

   // Operation request from the datapath; operand a is the accumulator
   typedef struct packed {
      cpsr_op_e   op;
      logic [7:0] operand_b;
   } cpsr_exec_s;

   // Result and flags of one operation
   typedef struct packed {
      logic [7:0] result;
      logic       cy;
      logic       ac;
      logic       ov;
   } cpsr_flags_s;

   // Whole state of the register block
   typedef struct packed {
      logic [7:0]  sp;
      logic [7:0]  data_pointer_low;
      logic [7:0]  data_pointer_high;
      logic [7:0]  acc;
      logic        cy;
      logic        ac;
      logic        f0;
      logic [1:0]  bank;
      logic        ov;
      logic        f1;
      logic        parity;
      logic [4:0]  bank_base;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        stk_we;
      logic [7:0]  stk_addr;
      logic [7:0]  stk_data;
   } cpsr_state_s;

endpackage

// File: cpsr_parity.sv
`timescale 1ns/1ps

// ==========================================================
// Odd-parity reduction over a word
module cpsr_parity #(
   parameter int WIDTH = 8
) (
   input  wire logic [WIDTH-1:0] data,
   output logic                  odd
);

   assign odd = ^data;

endmodule

// File: cpsr_alu_flags.sv
`timescale 1ns/1ps
`include "cpsr_defs.svh"

// ==========================================================
// Result and flag computation for the arithmetic operations
module cpsr_alu_flags
   import cpsr_pkg::*;
(
   input  wire cpsr_op_e    op,
   input  wire logic [7:0]  a,
   input  wire logic [7:0]  b,
   input  wire logic        cy_in,
   output cpsr_flags_s      flags
);

   logic [8:0]  wide;
   logic [4:0]  nib;
   logic [15:0] prod;
   logic        cin;

   // One adder serves both adds, a separate subtractor the borrow op; divide by zero keeps a and sets overflow
   always_comb begin
      flags = '0;
      cin   = (op == CPSR_OP_ADD) ? 1'b0 : cy_in;
      wide  = '0;
      nib   = '0;
      prod  = {8'h00, a} * {8'h00, b};
      unique case (op)
         CPSR_OP_ADD, CPSR_OP_ADD_WITH_CARRY_OP: begin
            wide = {1'b0, a} + {1'b0, b} + {8'h00, cin};
            nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
            flags.result = wide[7:0];
            flags.cy     = wide[8];
            flags.ac     = nib[4];
            flags.ov = (a[7] == b[7]) && (wide[7] != a[7]);
         end
         CPSR_OP_SUBTRACT_BORROW_OP: begin
            wide = {1'b0, a} - {1'b0, b} - {8'h00, cin};
            nib = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
            flags.result = wide[7:0];
            flags.cy     = wide[8];
            flags.ac     = nib[4];
            flags.ov = (a[7] != b[7]) && (wide[7] != a[7]);
         end
         CPSR_OP_MUL: begin
            flags.result = prod[7:0];
            flags.ov = prod > `CPSR_MUL_MAX;
         end
         CPSR_OP_DIV: begin
            flags.result = (b == 8'h00) ? a : a / b;
            flags.ov     = (b == 8'h00);
         end
         CPSR_OP_NONE: begin
            flags.result = a;
         end
      endcase
   end

endmodule

// File: cpsr_dp_model.sv
`timescale 1ns/1ps

// ==========================================================
// Datapath stand-in: one request per put call
module cpsr_dp_model
   import cpsr_pkg::*;
(
   input  wire logic  pclk,
   output cpsr_exec_s exec,
   output logic       acc_load,
   output logic [7:0] acc_value,
   output logic       push_req,
   output logic [7:0] push_data,
   output logic       pop_req,
   output logic       data_pointer_word_load,
   output logic [15:0] data_pointer_word_value
);
   // Quiet start before the first request
   initial begin
      exec = '0;
      acc_load = 1'b0;
      acc_value = 8'h00;
      push_req = 1'b0;
      push_data = 8'h00;
      pop_req = 1'b0;
      data_pointer_word_load = 1'b0;
      data_pointer_word_value = 16'h0000;
   end

   // Unused data lines flip so a stale value can never pass for a real one
   task automatic put(input cpsr_op_e k, input logic [7:0] b,
                      input logic al, pu, po, dl,
                      input logic [7:0] v8, input logic [15:0] v16);
      @(posedge pclk);
      exec.op <= k;
      exec.operand_b <= (k == CPSR_OP_NONE) ? ~exec.operand_b : b;
      acc_load <= al;
      push_req <= pu;
      pop_req <= po;
      data_pointer_word_load <= dl;
      acc_value <= al ? v8 : ~acc_value;
      push_data <= pu ? v8 : ~push_data;
      data_pointer_word_value <= dl ? v16 : ~data_pointer_word_value;
   endtask
endmodule

// File: cpu_core_status_pointer_regs_bench.sv
`timescale 1ns/1ps
`include "cpsr_defs.svh"

module cpu_core_status_pointer_regs_bench
   import cpsr_pkg::*;
;
   typedef struct {
      string       what;
      logic        rd;
      logic [31:0] data;
      logic        err;
   } cpsr_note_s;

   logic        pclk, presetn, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  pstrb;
   logic        pready, pslverr, acc_load, push_req, pop_req, data_pointer_word_load;
   logic        stk_we;
   cpsr_exec_s  exec;
   logic [7:0]  acc_value, push_data, stk_addr, stk_data, sp_o, psw_o, acc_o;
   logic [15:0] data_pointer_word_value, data_pointer_word_o;
   logic [4:0]  bank_o;
   int          bad_count, samples_checked, cycles;
   cpsr_note_s  notes[$];
   logic [15:0] stk_q[$];
   logic [7:0]  r_sp, r_dpl, r_dph, r_acc, r_psw;

   // ==========================================================
   // Design and datapath model
   cpsr_regs #(.ADDR_W(12)) cpsr_regs_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .exec(exec),
      .acc_load(acc_load), .acc_value(acc_value), .push_req(push_req),
      .push_data(push_data), .pop_req(pop_req), .data_pointer_word_load(data_pointer_word_load),
      .data_pointer_word_value(data_pointer_word_value), .data_pointer_word(data_pointer_word_o),
      .stack_top_pointer(sp_o), .program_status_word(psw_o),
      .primary_operand_register(acc_o), .bank_base(bank_o),
      .stk_we(stk_we), .stk_addr(stk_addr), .stk_data(stk_data));

   cpsr_dp_model cpsr_dp_model_inst (
      .pclk(pclk), .exec(exec), .acc_load(acc_load),
      .acc_value(acc_value), .push_req(push_req), .push_data(push_data),
      .pop_req(pop_req), .data_pointer_word_load(data_pointer_word_load), .data_pointer_word_value(data_pointer_word_value));

   // 40 MHz clock
   always #12.5 pclk = ~pclk;

   // ==========================================================
   // Checking helpers
   task automatic check(input string what, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic close_out;
      if (notes.size() != 0 || stk_q.size() != 0) bad_count++;
      $display("compared %0d mismatched %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Reference flags; parity is left to the state compare
   function automatic logic [10:0] alu(input cpsr_op_e k,
                                       input logic [7:0] a, b,
                                       input logic c);
      logic [8:0]  s;
      logic [4:0]  n;
      logic [15:0] p;
      case (k)
         CPSR_OP_ADD, CPSR_OP_ADD_WITH_CARRY_OP: begin
            c = (k == CPSR_OP_ADD_WITH_CARRY_OP) & c;
            s = a + b + c;
            n = a[3:0] + b[3:0] + c;
            return {s[7:0], s[8], n[4], (a[7] == b[7]) && (s[7] != a[7])};
         end
         CPSR_OP_SUBTRACT_BORROW_OP: begin
            s = {1'b0, a} - b - c;
            n = {1'b0, a[3:0]} - b[3:0] - c;
            return {s[7:0], s[8], n[4], (a[7] != b[7]) && (s[7] != a[7])};
         end
         CPSR_OP_MUL: begin
            p = a * b;
            return {p[7:0], 2'b00, p > 16'h00ff};
         end
         default: return (b == 0) ? {a, 2'b00, 1'b1} : {a / b, 3'b000};
      endcase
   endfunction

   // Compares every register output with the reference copy
   task automatic chk_state;
      check("sp", sp_o, r_sp);
      check("data_pointer_word", data_pointer_word_o, {r_dph, r_dpl});
      check("acc", acc_o, r_acc);
      check("psw", psw_o, {r_psw[7:1], ^r_acc});
      check("bank", bank_o, {r_psw[4:3], 3'b000});
   endtask

   // ==========================================================
   // APB master; holds the request until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] idx,
                      input logic [31:0] wd, exp, input logic err,
                      input string what);
      notes.push_back('{what, !wr, exp, err});
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= wd;
      pstrb <= (what == "strobe") ? 4'he : 4'h1;
      @(posedge pclk);
      penable <= 1'b1;
      // Ends when pready is sampled high; only the bench timeout ends a wait that never sees it
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~wd;
   endtask

   task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 32'h0, {24'h0, exp}, 1'b0, "read");
   endtask

   // upper bits always written as zero
   task automatic wr(input logic [7:0] idx, input logic [7:0] v);
      apb(1'b1, idx, {24'h0, v}, 32'h0, 1'b0, "write");
   endtask

   // Watcher: oldest note against each completed transfer, oldest stack entry against each push
   always @(posedge pclk) begin
      cpsr_note_s nt;
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         close_out;
      end
      if (psel && penable && pready === 1'b1) begin
         nt = notes.pop_front();
         check(nt.what, {31'h0, pslverr}, {31'h0, nt.err});
         if (nt.rd) check(nt.what, prdata, nt.data);
      end
      if (stk_we === 1'b1) begin
         if (stk_q.size() == 0) bad_count++;
         else check("push", {stk_addr, stk_data}, stk_q.pop_front());
      end
   end

   // ==========================================================
   // Main sequence
   initial begin
      int   i;
      logic [31:0] v;
      logic [7:0]  a, b;
      cpsr_op_e    k;
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      v = $urandom(50060);
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      {r_sp, r_dpl, r_dph, r_acc, r_psw} = {`CPSR_RST_SP, 32'h0};
      #1 chk_state;
      // Reset values over the bus
      rd(`CPSR_IDX_SP, 8'h07);
      rd(`CPSR_IDX_DPL, 8'h00);
      rd(`CPSR_IDX_DPH, 8'h00);
      rd(`CPSR_IDX_PSW, 8'h00);
      rd(`CPSR_IDX_ACC, 8'h00);
      // Reserved and undefined places answer with an error and no data
      apb(1'b0, `CPSR_IDX_RSV_LO, 32'h0, 32'h0, 1'b1, "rsv_lo");
      apb(1'b0, `CPSR_IDX_RSV_HI, 32'h0, 32'h0, 1'b1, "rsv_hi");
      apb(1'b1, 8'h84, 32'h5a, 32'h0, 1'b1, "gap");
      // Pointer bytes written by software, strobe-less write dropped
      v = $urandom;
      wr(`CPSR_IDX_DPL, v[7:0]);
      wr(`CPSR_IDX_DPH, v[15:8]);
      {r_dph, r_dpl} = v[15:0];
      apb(1'b1, `CPSR_IDX_ACC, 32'ha5, 32'h0, 1'b0, "strobe");
      rd(`CPSR_IDX_DPL, r_dpl);
      rd(`CPSR_IDX_DPH, r_dph);
      rd(`CPSR_IDX_ACC, 8'h00);
      #1 chk_state;
      // Every bank, user flags set, parity bit write ignored
      // Even accumulator, so a parity bit written as one would show
      wr(`CPSR_IDX_ACC, 8'h06);
      r_acc = 8'h06;
      for (i = 0; i < 4; i++) begin
         r_psw = {3'b001, i[1:0], 3'b010};
         wr(`CPSR_IDX_PSW, r_psw | 8'h01);
         rd(`CPSR_IDX_PSW, {r_psw[7:1], 1'b0});
         #1 chk_state;
      end
      // Whole pointer from the datapath
      v = $urandom;
      cpsr_dp_model_inst.put(CPSR_OP_NONE, 0, 0, 0, 0, 1, 0, v[15:0]);
      cpsr_dp_model_inst.put(CPSR_OP_NONE, 0, 0, 0, 0, 0, 0, 0);
      {r_dph, r_dpl} = v[15:0];
      #1 chk_state;
      // Two pushes back to back, then one pop
      for (i = 0; i < 2; i++) begin
         v = $urandom;
         r_sp++;
         stk_q.push_back({r_sp, v[7:0]});
         cpsr_dp_model_inst.put(CPSR_OP_NONE, 0, 0, 1, 0, 0, v[7:0], 0);
      end
      cpsr_dp_model_inst.put(CPSR_OP_NONE, 0, 0, 0, 1, 0, 0, 0);
      cpsr_dp_model_inst.put(CPSR_OP_NONE, 0, 0, 0, 0, 0, 0, 0);
      r_sp--;
      #1 chk_state;
      rd(`CPSR_IDX_SP, r_sp);
      // Arithmetic sweep, boundaries first, divide by zero every tenth
      for (i = 0; i < 60; i++) begin
         k = cpsr_op_e'(3'(1 + i % 5));
         a = (i < 5) ? 8'hff : 8'($urandom);
         b = (i < 5) ? 8'h01 : ((i % 10 == 4) ? 8'h00 : 8'($urandom));
         cpsr_dp_model_inst.put(CPSR_OP_NONE, 0, 1, 0, 0, 0, a, 0);
         cpsr_dp_model_inst.put(k, b, 0, 0, 0, 0, 0, 0);
         cpsr_dp_model_inst.put(CPSR_OP_NONE, 0, 0, 0, 0, 0, 0, 0);
         {r_acc, r_psw[7], r_psw[6], r_psw[2]} =
            alu(k, a, b, r_psw[7]);
         #1 chk_state;
      end
      // Second reset in mid-run
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      {r_sp, r_dpl, r_dph, r_acc, r_psw} = {`CPSR_RST_SP, 32'h0};
      #1 chk_state;
      rd(`CPSR_IDX_SP, 8'h07);
      repeat (3) @(posedge pclk);
      close_out;
   end
endmodule
